/* File: logic/bstenc_consts.svh */
// constants for the boot status reply encoder
`ifndef BSTENC_CONSTS_SVH
`define BSTENC_CONSTS_SVH
`define BSTENC_REPLY_OK        8'h00
`define BSTENC_REPLY_ERR       8'h80
`define BSTENC_ST_OK           8'h00
`define BSTENC_ST_UNSUP        8'hC0
`define BSTENC_ST_PACKET       8'hC1
`define BSTENC_ST_CHECKSUM     8'hC2
`define BSTENC_ST_PARAM        8'hD0
`define BSTENC_ST_ADDRESS      8'hD2
`define BSTENC_ST_CERT         8'hD3
`define BSTENC_ST_ACCEPT       8'hD5
`define BSTENC_ST_LC_UNMATCH   8'hD6
`define BSTENC_ST_HARDWARE     8'hD7
`define BSTENC_ST_PROTECT      8'hDA
`define BSTENC_ST_TRUSTED      8'hDB
`define BSTENC_ST_BOOTVER      8'hDC
`define BSTENC_ST_SECURE       8'hE4
`define BSTENC_ST_FLASH        8'hE5
`define BSTENC_ST_FLASH_INIT   8'hE7
`define BSTENC_ST_VERIFY       8'hE8
`define BSTENC_UNUSED_WORD     32'hFFFF_FFFF
`define BSTENC_TRUST_MANIFEST  32'hAAAA_0100
`define BSTENC_TRUST_CRYPTO    32'hAAAA_0200
`define BSTENC_TRUST_CRC       32'hAAAA_0300
`define BSTENC_LC_MAKER_DEV    8'h04
`define BSTENC_LC_LOCKED_BOOT  8'h06
`define BSTENC_LC_RET_REQ      8'h07
`define BSTENC_LC_RET_ACK      8'h08
`define BSTENC_LC_RETURNED     8'h09
`define BSTENC_START_BYTE      8'h81
`define BSTENC_END_BYTE        8'h03
`define BSTENC_STATUS_LEN      16'h000A
`define BSTENC_LAST_DATA       4'hA
`endif

/* File: logic/bstenc_pkg.sv */
// types for the boot status reply encoder
package bstenc_pkg;
  typedef enum logic [4:0] {
    BSTENC_F_NONE      = 5'd0,
    BSTENC_F_UNSUP     = 5'd1,
    BSTENC_F_PACKET    = 5'd2,
    BSTENC_F_CHECKSUM  = 5'd3,
    BSTENC_F_PARAM     = 5'd4,
    BSTENC_F_ADDRESS   = 5'd5,
    BSTENC_F_CERT      = 5'd6,
    BSTENC_F_ACCEPT    = 5'd7,
    BSTENC_F_LC_UNMATCH = 5'd8,
    BSTENC_F_HARDWARE  = 5'd9,
    BSTENC_F_PROTECT   = 5'd10,
    BSTENC_F_TRUSTED   = 5'd11,
    BSTENC_F_BOOTVER   = 5'd12,
    BSTENC_F_SECURE    = 5'd13,
    BSTENC_F_FLASH     = 5'd14,
    BSTENC_F_VERIFY    = 5'd15,
    BSTENC_F_FLASH_INIT = 5'd16
  } bstenc_fail_t;

  typedef enum logic [1:0] {
    BSTENC_T_MANIFEST = 2'd0,
    BSTENC_T_CRYPTO   = 2'd1,
    BSTENC_T_CRC      = 2'd2
  } bstenc_trust_t;

  typedef enum logic [2:0] {
    BSTENC_LC_MAKER_DEV   = 3'd0,
    BSTENC_LC_LOCKED_BOOT = 3'd1,
    BSTENC_LC_RET_REQ     = 3'd2,
    BSTENC_LC_RET_ACK     = 3'd3,
    BSTENC_LC_RETURNED    = 3'd4
  } bstenc_lc_t;

  typedef struct packed {
    logic [7:0]    command_code;
    bstenc_fail_t  fail_class;
    bstenc_trust_t trust_class;
    logic [7:0]    trust_sub;
    logic          seq_locked;
    logic [31:0]   flash_sequencer_flags;
    logic [31:0]   seq_start_addr;
  } bstenc_req_t;

  typedef struct packed {
    logic [7:0]  reply_code;
    logic [7:0]  outcome_code;
    logic [31:0] outcome_details;
    logic [31:0] fail_addr;
  } bstenc_status_t;
endpackage

/* File: logic/bstenc_top.sv */
// boot status reply encoder: builds and streams the status reply frame
`timescale 1ns/1ns
`include "bstenc_consts.svh"

module bstenc_top (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  req_valid_i,
  output logic                       req_ready_o,
  input  wire bstenc_pkg::bstenc_req_t req_i,
  input  wire bstenc_pkg::bstenc_lc_t  lc_i,
  output logic [7:0]                 lifecycle_state_o,
  output logic                       tx_valid_o,
  input  wire logic                  tx_ready_i,
  output logic [7:0]                 tx_data_o,
  output logic                       tx_last_o,
  output bstenc_pkg::bstenc_status_t status_o,
  output logic                       flash_flags_clear_o
);
  import bstenc_pkg::*;

  typedef enum logic [1:0] {
    BSTENC_S_IDLE = 2'b01,
    BSTENC_S_SEND = 2'b10
  } bstenc_state_t;

  bstenc_state_t  state;
  bstenc_status_t held;
  logic [3:0]     idx;
  logic [7:0]     sum;
  logic [7:0]     next_sum;
  logic [7:0]     next_outcome;
  logic           take;
  logic           byte_done;

  function automatic logic [7:0] outcome_of(input bstenc_fail_t f, input logic locked);
    logic [7:0] v;
    v = `BSTENC_ST_OK;
    unique case (f)
      BSTENC_F_UNSUP:      v = `BSTENC_ST_UNSUP;
      BSTENC_F_PACKET:     v = `BSTENC_ST_PACKET;
      BSTENC_F_CHECKSUM:   v = `BSTENC_ST_CHECKSUM;
      BSTENC_F_PARAM:      v = `BSTENC_ST_PARAM;
      BSTENC_F_ADDRESS:    v = `BSTENC_ST_ADDRESS;
      BSTENC_F_CERT:       v = `BSTENC_ST_CERT;
      BSTENC_F_ACCEPT:     v = `BSTENC_ST_ACCEPT;
      BSTENC_F_LC_UNMATCH: v = `BSTENC_ST_LC_UNMATCH;
      BSTENC_F_HARDWARE:   v = `BSTENC_ST_HARDWARE;
      BSTENC_F_PROTECT:    v = `BSTENC_ST_PROTECT;
      BSTENC_F_TRUSTED:    v = `BSTENC_ST_TRUSTED;
      BSTENC_F_BOOTVER:    v = `BSTENC_ST_BOOTVER;
      BSTENC_F_SECURE:     v = `BSTENC_ST_SECURE;
      BSTENC_F_FLASH:      v = `BSTENC_ST_FLASH;
      BSTENC_F_VERIFY:     v = `BSTENC_ST_VERIFY;
      BSTENC_F_FLASH_INIT: v = `BSTENC_ST_FLASH_INIT;
      default:             v = `BSTENC_ST_OK;
    endcase
    // a command lock outranks whatever class the procedure reported
    if (locked) begin
      v = `BSTENC_ST_FLASH;
    end
    return v;
  endfunction

  function automatic logic [31:0] trust_word(input bstenc_trust_t t, input logic [7:0] sub);
    logic [31:0] w;
    unique case (t)
      BSTENC_T_CRYPTO: w = `BSTENC_TRUST_CRYPTO;
      BSTENC_T_CRC:    w = `BSTENC_TRUST_CRC;
      default:         w = `BSTENC_TRUST_MANIFEST;
    endcase
    return {w[31:8], sub};
  endfunction

  assign take         = (state == BSTENC_S_IDLE) && req_valid_i;
  assign req_ready_o  = (state == BSTENC_S_IDLE);
  assign byte_done    = (state == BSTENC_S_SEND) && tx_ready_i;
  assign next_outcome = outcome_of(req_i.fail_class, req_i.seq_locked);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= BSTENC_S_IDLE;
    end else if (take) begin
      state <= BSTENC_S_SEND;
    end else if (byte_done && tx_last_o) begin
      state <= BSTENC_S_IDLE;
    end
  end

  // held contents stay frozen for the whole frame
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held <= '0;
    end else if (take) begin
      held.outcome_code <= next_outcome;
      if (next_outcome != `BSTENC_ST_OK) begin
        held.reply_code <= req_i.command_code + `BSTENC_REPLY_ERR;
      end else begin
        held.reply_code <= req_i.command_code + `BSTENC_REPLY_OK;
      end
      if (next_outcome == `BSTENC_ST_FLASH) begin
        held.outcome_details <= req_i.flash_sequencer_flags;
        held.fail_addr       <= req_i.seq_start_addr;
      end else if (next_outcome == `BSTENC_ST_TRUSTED) begin
        held.outcome_details <= trust_word(req_i.trust_class, req_i.trust_sub);
        held.fail_addr       <= `BSTENC_UNUSED_WORD;
      end else begin
        held.outcome_details <= `BSTENC_UNUSED_WORD;
        held.fail_addr       <= `BSTENC_UNUSED_WORD;
      end
    end
  end

  assign status_o = held;

  // byte index: 0 start, 1-2 length, 3 reply, 4-12 data, 13 sum, 14 end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx <= 4'h0;
    end else if (take) begin
      idx <= 4'h0;
    end else if (byte_done) begin
      idx <= idx + 4'h1;
    end
  end

  function automatic logic [7:0] frame_byte(input logic [3:0] i, input bstenc_status_t h, input logic [7:0] s);
    logic [7:0] b;
    b = `BSTENC_END_BYTE;
    unique case (i)
      4'd0:  b = `BSTENC_START_BYTE;
      4'd1:  b = 8'(`BSTENC_STATUS_LEN >> 8);
      4'd2:  b = 8'(`BSTENC_STATUS_LEN);
      4'd3:  b = h.reply_code;
      4'd4:  b = h.outcome_code;
      4'd5:  b = h.outcome_details[31:24];
      4'd6:  b = h.outcome_details[23:16];
      4'd7:  b = h.outcome_details[15:8];
      4'd8:  b = h.outcome_details[7:0];
      4'd9:  b = h.fail_addr[31:24];
      4'd10: b = h.fail_addr[23:16];
      4'd11: b = h.fail_addr[15:8];
      4'd12: b = h.fail_addr[7:0];
      4'd13: b = 8'h00 - s;
      default: b = `BSTENC_END_BYTE;
    endcase
    return b;
  endfunction

  // output byte is a register; the next one is loaded as the current one is taken
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_data_o <= 8'h00;
    end else if (take) begin
      tx_data_o <= `BSTENC_START_BYTE;
    end else if (byte_done) begin
      tx_data_o <= frame_byte(idx + 4'h1, held, next_sum);
    end
  end

  assign tx_valid_o = (state == BSTENC_S_SEND);
  assign tx_last_o  = (idx == 4'd14);

  // running sum over length, reply and data bytes only
  // the sum byte is loaded from the updated sum so the last data byte is counted
  assign next_sum = (byte_done && idx >= 4'd1 && idx <= 4'd12) ? sum + tx_data_o : sum;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sum <= 8'h00;
    end else if (take) begin
      sum <= 8'h00;
    end else begin
      sum <= next_sum;
    end
  end

  // flags are cleared only once the whole frame has left
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_flags_clear_o <= 1'b0;
    end else begin
      flash_flags_clear_o <= byte_done && tx_last_o;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lifecycle_state_o <= `BSTENC_LC_MAKER_DEV;
    end else begin
      unique case (lc_i)
        BSTENC_LC_LOCKED_BOOT: lifecycle_state_o <= `BSTENC_LC_LOCKED_BOOT;
        BSTENC_LC_RET_REQ:     lifecycle_state_o <= `BSTENC_LC_RET_REQ;
        BSTENC_LC_RET_ACK:     lifecycle_state_o <= `BSTENC_LC_RET_ACK;
        BSTENC_LC_RETURNED:    lifecycle_state_o <= `BSTENC_LC_RETURNED;
        default:               lifecycle_state_o <= `BSTENC_LC_MAKER_DEV;
      endcase
    end
  end
endmodule // bstenc_top

/* File: dv/bstenc_properties.sv */
// assertion checker for the status reply encoder
`timescale 1ns/1ns
module bstenc_props (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire logic                       req_valid_i,
  input wire logic                       req_ready_o,
  input wire bstenc_pkg::bstenc_req_t    req_i,
  input wire bstenc_pkg::bstenc_lc_t     lc_i,
  input wire logic [7:0]                 lifecycle_state_o,
  input wire logic                       tx_valid_o,
  input wire logic                       tx_ready_i,
  input wire logic [7:0]                 tx_data_o,
  input wire logic                       tx_last_o,
  input wire bstenc_pkg::bstenc_status_t status_o,
  input wire logic                       flash_flags_clear_o
);
  import bstenc_pkg::*;
  logic tk;
  assign tk = req_valid_i && req_ready_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_frame_start: assert property (tk |=> tx_valid_o && tx_data_o == 8'h81 && !req_ready_o)
    else $error("frame did not open with start byte");
  a_byte_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("byte changed while host stalled");
  a_end_byte: assert property (tx_last_o |-> tx_valid_o && tx_data_o == 8'h03)
    else $error("last byte is not the end byte");
  a_flags_clear: assert property (tx_last_o && tx_ready_i |=> flash_flags_clear_o && req_ready_o && !tx_valid_o)
    else $error("no flag clear after frame end");
  a_reply_form: assert property (tk |=> status_o.reply_code ==
    $past(req_i.command_code) + ((status_o.outcome_code != 8'h00) ? 8'h80 : 8'h00))
    else $error("reply code does not match outcome");
  a_lock_flash: assert property (tk && req_i.seq_locked |=> status_o.outcome_code == 8'hE5 &&
    status_o.fail_addr == $past(req_i.seq_start_addr))
    else $error("sequencer lock not reported as flash error");
  a_clean_ok: assert property (tk && req_i.fail_class == BSTENC_F_NONE && !req_i.seq_locked |=>
    status_o == {$past(req_i.command_code), 8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF})
    else $error("clean result not reported as ok");
  a_status_hold: assert property (!tk |=> $stable(status_o))
    else $error("status moved without a new request");
  a_busy_refuse: assert property (tx_valid_o |-> !req_ready_o)
    else $error("ready while a frame is pending");
  a_lc_locked: assert property (lc_i == BSTENC_LC_LOCKED_BOOT |=> lifecycle_state_o == 8'h06)
    else $error("wrong locked boot code");
endmodule // bstenc_props
bind bstenc_top bstenc_props props (.clk_i, .sys_rst_i, .req_valid_i, .req_ready_o, .req_i, .lc_i,
  .lifecycle_state_o, .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_last_o, .status_o, .flash_flags_clear_o);

/* File: dv/bstenc_host_sink.sv */
// byte sink standing in for the host tool on the reply link
`timescale 1ns/1ns
module bstenc_host_sink (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic stall_i,
  output logic      ready_o
);
  // pausing every other cycle exposes any encoder that skips a held byte
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ready_o <= 1'b0;
    else ready_o <= stall_i ? ~ready_o : 1'b1;
  end
endmodule // bstenc_host_sink

/* File: dv/tb.sv */
// self-checking bench for the status reply encoder
`timescale 1ns/1ns
module tb;
  import bstenc_pkg::*;
  logic           clk_i = 0, sys_rst_i = 1, req_valid_i = 0, stall = 0;
  bstenc_req_t    req_i = '0;
  bstenc_lc_t     lc_i = BSTENC_LC_MAKER_DEV;
  logic           req_ready_o, tx_valid_o, tx_ready_i, tx_last_o, flash_flags_clear_o;
  logic [7:0]     lifecycle_state_o, tx_data_o;
  bstenc_status_t status_o;
  int             failures = 0, compares = 0, cyc = 0;
  bstenc_top dut (.clk_i, .sys_rst_i, .req_valid_i, .req_ready_o, .req_i, .lc_i, .lifecycle_state_o,
    .tx_valid_o, .tx_ready_i, .tx_data_o, .tx_last_o, .status_o, .flash_flags_clear_o);
  bstenc_host_sink host (.clk_i, .sys_rst_i, .stall_i(stall), .ready_o(tx_ready_i));
  initial forever #20 clk_i = ~clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // one request, whole frame captured at falling edges, expected bytes built here
  task automatic run(input bstenc_req_t r, input logic [7:0] st, input logic [31:0] det, input logic [31:0] adr);
    logic [7:0] got[$];
    logic [7:0] exp[15];
    logic [7:0] rc;
    int n;
    rc = r.command_code + ((st != 8'h00) ? 8'h80 : 8'h00);
    exp = '{8'h81, 8'h00, 8'h0A, rc, st, det[31:24], det[23:16], det[15:8], det[7:0],
      adr[31:24], adr[23:16], adr[15:8], adr[7:0], 8'h00, 8'h03};
    for (n = 1; n < 13; n++) exp[13] -= exp[n];
    req_i = r;
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
    n = 0;
    while (got.size() < 15 && n < 100) begin
      if (n == 0) check(req_ready_o, 0);
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
        check(tx_last_o, got.size() == 14);
        got.push_back(tx_data_o);
      end
      @(negedge clk_i);
      n++;
    end
    check(req_ready_o, 1);
    check(flash_flags_clear_o, 1);
    check(got.size(), 15);
    foreach (got[i]) check(got[i], exp[i]);
    check(status_o.outcome_details, det);
    check(status_o.fail_addr, adr);
    check({status_o.reply_code, status_o.outcome_code}, {rc, st});
  endtask
  // a reset in mid-frame drops the frame and the held status at once
  task automatic t_reset;
    bstenc_req_t r;
    r = '0;
    r.command_code = 8'h15;
    r.seq_locked = 1;
    r.flash_sequencer_flags = 32'h0000_0010;
    r.seq_start_addr = 32'h0000_2000;
    lc_i = BSTENC_LC_RETURNED;
    req_i = r;
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
    repeat (4) @(negedge clk_i);
    check(tx_valid_o, 1);
    sys_rst_i = 1;
    @(negedge clk_i);
    check(tx_valid_o, 0);
    check(req_ready_o, 1);
    check(flash_flags_clear_o, 0);
    check(status_o.outcome_details, 0);
    check(lifecycle_state_o, 8'h04);
    sys_rst_i = 0;
    lc_i = BSTENC_LC_MAKER_DEV;
    run(r, 8'hE5, 32'h0000_0010, 32'h0000_2000);
  endtask
  task automatic t_codes;
    logic [7:0] st[17] = '{8'h00, 8'hC0, 8'hC1, 8'hC2, 8'hD0, 8'hD2, 8'hD3, 8'hD5, 8'hD6,
      8'hD7, 8'hDA, 8'hDB, 8'hDC, 8'hE4, 8'hE5, 8'hE8, 8'hE7};
    bstenc_req_t r;
    for (int i = 0; i < 17; i++) begin
      r = '0;
      r.command_code = {i[3:0], 4'h1};
      r.fail_class = bstenc_fail_t'(i);
      r.trust_sub = 8'h07;
      r.flash_sequencer_flags = 32'h1357_9BDF;
      r.seq_start_addr = 32'h0001_2340;
      run(r, st[i], (i == 14) ? 32'h1357_9BDF : (i == 11) ? 32'hAAAA_0107 : 32'hFFFF_FFFF,
        (i == 14) ? 32'h0001_2340 : 32'hFFFF_FFFF);
    end
  endtask
  task automatic t_trusted;
    bstenc_req_t r;
    stall = 1;
    for (int k = 0; k < 3; k++) begin
      r = '0;
      r.command_code = 8'h27;
      r.fail_class = BSTENC_F_TRUSTED;
      r.trust_class = bstenc_trust_t'(k);
      r.trust_sub = 8'h3C;
      run(r, 8'hDB, {16'hAAAA, 8'(k + 1), 8'h3C}, 32'hFFFF_FFFF);
    end
    stall = 0;
  endtask
  task automatic t_locked;
    bstenc_req_t r;
    stall = 1;
    r = '0;
    r.command_code = 8'h13;
    r.fail_class = BSTENC_F_PARAM;
    r.seq_locked = 1;
    r.flash_sequencer_flags = 32'h0000_8001;
    r.seq_start_addr = 32'h0800_0100;
    run(r, 8'hE5, 32'h0000_8001, 32'h0800_0100);
    r = '0;
    r.command_code = 8'h71;
    run(r, 8'h00, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    stall = 0;
  endtask
  task automatic t_lifecycle;
    logic [7:0] code[5] = '{8'h04, 8'h06, 8'h07, 8'h08, 8'h09};
    for (int k = 4; k >= 0; k--) begin
      lc_i = bstenc_lc_t'(k);
      @(negedge clk_i);
      check(lifecycle_state_o, code[k]);
    end
  endtask
  initial begin
    repeat (16) @(negedge clk_i);
    sys_rst_i = 0;
    t_lifecycle();
    t_codes();
    t_trusted();
    t_locked();
    t_reset();
    wrap_up();
  end
endmodule // tb
